// file: core/phy_frame_control_registers.sv
// Overview of operation
// [RL1] tx control bit 0 picks tx preamble
// [RL2] tx control bits 3:2 pick tx antenna
// [RL3] tx control bits 7:4 index tx power
// [RL4] rx channel bits 5:0, reset zero
// [RL5] rx control bit 0 picks rx preamble
// [RL6] rx control bit 1 enables header preamble use
// [RL7] rx control bits 3:2 pick rx antenna
// [RL8] read-only 32-bit ranging counter, resets zero
// [RL9] ranging counter read byte by byte
// [RL10] host writes tx registers before tx enable
// [RL11] host holds tx registers after tx enable
// [RL12] device samples tx registers within hold window
// [RL13] host writes rx registers before rx enable
// [RL14] host holds rx registers after rx enable
// [RL15] first rx sample uses register preamble only
// [RL16] burst: host writes rx registers before frame end
// [RL17] burst: resample rx registers after frame end
// [RL18] burst header bits may override rx preamble
// [RL19] rx enable toggle wins, reloads rx parameters
// [RL20] channel: band group high, tfc low
// [RL21] setup and hold figures are 0 to 128
`include "phy_frame_defs.svh"
`default_nettype none

module phy_frame_control_registers
    import phy_frame_pkg::*;
#(
    parameter int tx_param_setup_cycles = 0,
    parameter int tx_param_hold_cycles  = 0,
    parameter int rx_param_setup_cycles = 0,
    parameter int rx_param_hold_cycles  = 0,
    parameter int tx_sample_lag         = 0,
    parameter int rx_sample_lag         = 0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_en,
    input  wire logic        rx_en,
    input  wire logic        frame_active,
    input  wire logic        hdr_valid,
    input  wire logic        hdr_burst_mode_flag,
    input  wire logic        hdr_next_preamble_flag,
    input  wire logic        range_run,
    output tx_param_t        tx_param,
    output logic             tx_loaded,
    output rx_param_t        rx_param,
    output logic             rx_loaded,
    output logic      [2:0]  power_mode
);

    // refuse windows the sequencer cannot serve
    if (tx_param_setup_cycles < 0 || rx_param_setup_cycles < 0 ||
        tx_param_setup_cycles > `PARAM_WINDOW_MAX ||
        rx_param_setup_cycles > `PARAM_WINDOW_MAX ||
        tx_param_hold_cycles > `PARAM_WINDOW_MAX ||
        rx_param_hold_cycles > `PARAM_WINDOW_MAX) begin : g_bad_win
        $error("setup or hold figure outside 0..128"); // [RL21]
    end
    if (tx_sample_lag < 0 || tx_sample_lag > tx_param_hold_cycles ||
        rx_sample_lag < 0 || rx_sample_lag > rx_param_hold_cycles)
    begin : g_bad_lag
        $error("sample lag must lie inside the hold window");
    end

    ctl_state_t  s;
    ctl_state_t  n;
    logic [31:0] range_count;

    // ranging time base, counts only while range_run is high
    range_tick_counter u_range (
        .clk   (clk),
        .rst   (rst),
        .run   (range_run),
        .count (range_count)
    );

    always_comb begin
        logic [3:0]  idx;
        logic        hit;
        logic [31:0] rd;
        logic        tx_rise;
        logic        rx_rise;
        logic        act_fall;
        logic        do_tx;
        logic        do_rx;
        logic        use_hdr;
        idx      = paddr[5:2];
        hit      = 1'b0;
        rd       = 32'h0000_0000;
        tx_rise  = tx_en & ~s.tx_en_q;
        rx_rise  = rx_en & ~s.rx_en_q;
        act_fall = s.act_q & ~frame_active;
        do_tx    = 1'b0;
        do_rx    = 1'b0;
        use_hdr  = 1'b0;

        n           = s;
        n.pready    = 1'b0;
        n.pslverr   = 1'b0;
        n.tx_loaded = 1'b0;
        n.rx_loaded = 1'b0;
        n.tx_en_q   = tx_en;
        n.rx_en_q   = rx_en;
        n.act_q     = frame_active;

        // read mux, reserved bits read as zero
        case (idx)
            `IDX_TX_CHAN: begin
                hit = 1'b1;
                rd  = {26'h0, s.regs.transmit_channel};
            end
            `IDX_TX_CTL: begin
                hit = 1'b1;
                rd  = {24'h0, s.regs.transmit_control};
            end
            `IDX_RX_CHAN: begin
                hit = 1'b1;
                rd  = {26'h0, s.regs.receive_channel}; // [RL4]
            end
            `IDX_RX_CTL: begin
                hit = 1'b1;
                rd  = {28'h0, s.regs.receive_control};
            end
            `IDX_PM_MODE: begin
                hit = 1'b1;
                rd  = {29'h0, s.regs.power_mode};
            end
            `IDX_RANGE_B0: begin
                hit = 1'b1;
                rd  = {24'h0, range_count[7:0]}; // [RL9]
            end
            `IDX_RANGE_B1: begin
                hit = 1'b1;
                rd  = {24'h0, s.range_snap[7:0]}; // [RL9]
            end
            `IDX_RANGE_B2: begin
                hit = 1'b1;
                rd  = {24'h0, s.range_snap[15:8]}; // [RL9]
            end
            `IDX_RANGE_B3: begin
                hit = 1'b1;
                rd  = {24'h0, s.range_snap[23:16]}; // [RL9]
            end
            `IDX_CRD_EXT: begin
                hit = 1'b1;
                rd  = {24'h0, s.regs.regulatory_domain_ext};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end

        // access phase: answer after one wait cycle
        if (psel && penable && !s.pready) begin
            n.pready  = 1'b1;
            n.pslverr = ~hit;
            n.prdata  = hit ? rd : 32'h0000_0000;
            // low-byte read freezes the upper bytes for later reads
            if (hit && !pwrite && idx == `IDX_RANGE_B0) begin
                n.range_snap = range_count[31:8]; // [RL9]
            end
        end

        // writes land on the completing edge; counter bytes ignore writes
        if (psel && penable && s.pready && pwrite && !s.pslverr) begin
            case (idx)
                `IDX_TX_CHAN: begin
                    n.regs.transmit_channel = pwdata[`CHAN_MSB:0];
                end
                `IDX_TX_CTL: begin
                    n.regs.transmit_control = {pwdata[7:2], 1'b0,
                                               pwdata[0]};
                end
                `IDX_RX_CHAN: begin
                    n.regs.receive_channel = pwdata[`CHAN_MSB:0]; // [RL4]
                end
                `IDX_RX_CTL: begin
                    n.regs.receive_control = pwdata[3:0];
                end
                `IDX_PM_MODE: begin
                    n.regs.power_mode = pwdata[`PM_MSB:0];
                end
                `IDX_CRD_EXT: begin
                    n.regs.regulatory_domain_ext = pwdata[7:0];
                end
                default: begin
                    n.regs = s.regs;
                end
            endcase
        end

        // transmit: sample lag cycles after tx enable rises
        case (s.tx_st)
            ST_IDLE: begin
                if (tx_rise) begin
                    if (tx_sample_lag == 0) begin
                        do_tx   = 1'b1;
                        n.tx_st = ST_HELD;
                    end else begin
                        n.tx_cnt = 8'h01;
                        n.tx_st  = ST_LAG;
                    end
                end
            end
            ST_LAG: begin
                if (!tx_en) begin
                    n.tx_st = ST_IDLE;
                end else if (s.tx_cnt == 8'(tx_sample_lag)) begin
                    do_tx   = 1'b1; // [RL12]
                    n.tx_st = ST_HELD;
                end else begin
                    n.tx_cnt = s.tx_cnt + 8'h01;
                end
            end
            ST_HELD: begin
                if (!tx_en) begin
                    n.tx_st = ST_IDLE;
                end
            end
            default: begin
                n.tx_st = ST_IDLE;
            end
        endcase

        // latch the preamble flags of the header just received
        if (hdr_valid) begin
            n.last_burst    = hdr_burst_mode_flag;
            n.last_preamble = hdr_next_preamble_flag;
        end

        // receive: enable drop always returns to idle
        case (s.rx_st)
            ST_IDLE: begin
                if (rx_rise) begin
                    n.rx_burst = 1'b0; // [RL15]
                    if (rx_sample_lag == 0) begin
                        do_rx   = 1'b1;
                        n.rx_st = ST_HELD;
                    end else begin
                        n.rx_cnt = 8'h01;
                        n.rx_st  = ST_LAG;
                    end
                end
            end
            ST_LAG: begin
                if (!rx_en) begin
                    n.rx_st = ST_IDLE; // [RL19]
                end else if (s.rx_cnt == 8'(rx_sample_lag)) begin
                    do_rx   = 1'b1;
                    n.rx_st = ST_HELD;
                end else begin
                    n.rx_cnt = s.rx_cnt + 8'h01;
                end
            end
            ST_HELD: begin
                if (!rx_en) begin
                    n.rx_st = ST_IDLE; // [RL19]
                end else if (act_fall) begin
                    n.rx_burst = 1'b1; // [RL17]
                    if (rx_sample_lag == 0) begin
                        do_rx = 1'b1;
                    end else begin
                        n.rx_cnt = 8'h01;
                        n.rx_st  = ST_LAG;
                    end
                end
            end
            default: begin
                n.rx_st = ST_IDLE;
            end
        endcase

        // load transmit parameters for the frame of this enable
        if (do_tx) begin
            n.tx_loaded = 1'b1; // [RL12]
            n.tx_par.tx_preamble_kind =
                s.regs.transmit_control[`PREAMBLE_BIT]; // [RL1]
            n.tx_par.tx_antenna_select =
                s.regs.transmit_control[`ANT_MSB:`ANT_LSB]; // [RL2]
            n.tx_par.tx_power_index =
                s.regs.transmit_control[`PWR_MSB:`PWR_LSB]; // [RL3]
            n.tx_par.band_group =
                s.regs.transmit_channel[`CHAN_MSB:`BG_LSB]; // [RL20]
            n.tx_par.tfc = s.regs.transmit_channel[`TFC_MSB:0]; // [RL20]
        end

        // header flags only count inside a burst with header use on
        use_hdr = n.rx_burst && s.last_burst &&
                  s.regs.receive_control[`HDR_PROC_BIT]; // [RL18]
        if (do_rx) begin
            n.rx_loaded = 1'b1;
            n.rx_par.rx_preamble_kind = use_hdr ? s.last_preamble :
                s.regs.receive_control[`PREAMBLE_BIT]; // [RL5]
            n.rx_par.header_preamble_process_enable =
                s.regs.receive_control[`HDR_PROC_BIT]; // [RL6]
            n.rx_par.rx_antenna_select =
                s.regs.receive_control[`ANT_MSB:`ANT_LSB]; // [RL7]
            n.rx_par.band_group =
                s.regs.receive_channel[`CHAN_MSB:`BG_LSB]; // [RL20]
            n.rx_par.tfc = s.regs.receive_channel[`TFC_MSB:0]; // [RL20]
        end
    end

    // state register, constants only under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s                            <= '0;
            s.regs.transmit_channel      <= `RST_TX_CHAN;
            s.regs.transmit_control      <= `RST_TX_CTL;
            s.regs.receive_channel       <= `RST_RX_CHAN; // [RL4]
            s.regs.receive_control       <= `RST_RX_CTL;
            s.regs.power_mode            <= `RST_PM_MODE;
            s.regs.regulatory_domain_ext <= `RST_CRD_EXT;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state register
    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign tx_param   = s.tx_par;
    assign tx_loaded  = s.tx_loaded;
    assign rx_param   = s.rx_par;
    assign rx_loaded  = s.rx_loaded;
    assign power_mode = s.regs.power_mode;

endmodule : phy_frame_control_registers

`default_nettype wire

// file: core/phy_frame_defs.svh
`ifndef PHY_FRAME_DEFS_SVH
`define PHY_FRAME_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_TX_CHAN   4'h2
`define IDX_TX_CTL    4'h3
`define IDX_RX_CHAN   4'h4
`define IDX_RX_CTL    4'h5
`define IDX_PM_MODE   4'h6
`define IDX_RANGE_B0  4'h7
`define IDX_RANGE_B1  4'h8
`define IDX_RANGE_B2  4'h9
`define IDX_RANGE_B3  4'hA
`define IDX_CRD_EXT   4'hB

// field positions
`define PREAMBLE_BIT  0
`define HDR_PROC_BIT  1
`define ANT_LSB       2
`define ANT_MSB       3
`define PWR_LSB       4
`define PWR_MSB       7
`define CHAN_MSB      5
`define BG_LSB        3
`define TFC_MSB       2
`define PM_MSB        2

// reset values
`define RST_TX_CHAN   6'h00
`define RST_TX_CTL    8'h00
`define RST_RX_CHAN   6'h00
`define RST_RX_CTL    4'h0
`define RST_PM_MODE   3'h1
`define RST_CRD_EXT   8'h00

// timing
`define PARAM_WINDOW_MAX 128
`define RANGE_CLK_MHZ    4224
`define CORE_CLK_MHZ     10

`endif

// file: core/phy_frame_pkg.sv
`default_nettype none

package phy_frame_pkg;

    // sampling sequencer states, gray along idle -> lag -> held
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LAG  = 2'b01,
        ST_HELD = 2'b11
    } arm_st_t;

    typedef struct packed {
        logic       tx_preamble_kind;
        logic [1:0] tx_antenna_select;
        logic [3:0] tx_power_index;
        logic [2:0] band_group;
        logic [2:0] tfc;
    } tx_param_t;

    typedef struct packed {
        logic       rx_preamble_kind;
        logic       header_preamble_process_enable;
        logic [1:0] rx_antenna_select;
        logic [2:0] band_group;
        logic [2:0] tfc;
    } rx_param_t;

    typedef struct packed {
        logic [5:0] transmit_channel;
        logic [7:0] transmit_control;
        logic [5:0] receive_channel;
        logic [3:0] receive_control;
        logic [2:0] power_mode;
        logic [7:0] regulatory_domain_ext;
    } reg_file_t;

    typedef struct packed {
        reg_file_t   regs;
        logic [23:0] range_snap;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        arm_st_t     tx_st;
        arm_st_t     rx_st;
        logic [7:0]  tx_cnt;
        logic [7:0]  rx_cnt;
        logic        tx_en_q;
        logic        act_q;
        logic        rx_en_q;
        logic        rx_burst;
        logic        last_burst;
        logic        last_preamble;
        tx_param_t   tx_par;
        rx_param_t   rx_par;
        logic        tx_loaded;
        logic        rx_loaded;
    } ctl_state_t;

    typedef struct packed {
        logic [31:0] count;
        logic [3:0]  frac;
    } range_state_t;

endpackage : phy_frame_pkg

`default_nettype wire

// file: core/range_tick_counter.sv
`include "phy_frame_defs.svh"
`default_nettype none

module range_tick_counter
    import phy_frame_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    output logic      [31:0] count
);

    // fast-clock periods per core cycle, split in whole and remainder
    localparam int STEP = `RANGE_CLK_MHZ / `CORE_CLK_MHZ;
    localparam int REM  = `RANGE_CLK_MHZ % `CORE_CLK_MHZ;

    if (`CORE_CLK_MHZ > 15 || STEP < 1) begin : g_bad_rate
        $error("range counter rate ratio not supported");
    end

    range_state_t s;
    range_state_t n;

    // whole periods every run cycle, one extra when the remainder wraps
    always_comb begin
        n = s;
        if (run) begin
            n.frac  = s.frac + 4'(REM);
            n.count = s.count + 32'(STEP);
            if (n.frac >= 4'(`CORE_CLK_MHZ)) begin
                n.frac  = n.frac - 4'(`CORE_CLK_MHZ);
                n.count = n.count + 32'h0000_0001;
            end
        end
    end

    // counter resets to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0; // [RL8]
        end else begin
            s <= n;
        end
    end

    assign count = s.count;

endmodule : range_tick_counter

`default_nettype wire

// file: tb/mac_model.sv
`default_nettype none

module mac_model
    import phy_frame_pkg::*;
#(
    parameter int SU = 2,
    parameter int HO = 4
) (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [5:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             tx_en,
    output logic             rx_en
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] rd_q;
    logic        err_q;
    logic        hung_q;

    // idle bus and enables from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 6'h00;
        pwdata = 32'h0;
        tx_en = 1'b0;
        rx_en = 1'b0;
        hung_q = 1'b0;
    end

    // one apb transfer, request held until pready is seen high or 16 wait cycles pass
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        hung_q = (n >= 16);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    // tx enable pulse framed by setup and hold
    task automatic pulse_tx();
        repeat (SU) @(posedge clk);
        tx_en <= 1'b1;
        repeat (HO) @(posedge clk);
        tx_en <= 1'b0;
        @(posedge clk);
    endtask : pulse_tx

    // rx enable change framed by setup and hold
    task automatic set_rx(input logic v);
        repeat (SU) @(posedge clk);
        rx_en <= v;
        repeat (HO) @(posedge clk);
    endtask : set_rx
endmodule : mac_model

`default_nettype wire

// file: tb/phy_frame_checker.sv
`default_nettype none

module phy_frame_checker
    import phy_frame_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        tx_en,
    input  wire logic        rx_en,
    input  wire logic        frame_active,
    input  wire logic        hdr_valid,
    input  wire logic        hdr_burst_mode_flag,
    input  wire logic        hdr_next_preamble_flag,
    input  wire tx_param_t   tx_param,
    input  wire logic        tx_loaded,
    input  wire rx_param_t   rx_param,
    input  wire logic        rx_loaded
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0]  tch_q;
    logic [7:0]  tct_q;
    logic [5:0]  rch_q;
    logic [3:0]  rct_q;
    logic        hbm_q;
    logic        hpt_q;
    logic        wr_ok;
    logic        bad;
    logic [12:0] txp;
    logic [9:0]  rxp;
    logic [9:0]  rxb;

    // decode and expected parameter words
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign bad = paddr[1:0] != 2'h0 || paddr[5:2] < 4'h2
               || paddr[5:2] > 4'hB;
    assign txp = {tct_q[0], tct_q[3:2], tct_q[7:4], tch_q};
    assign rxp = {rct_q[0], rct_q[1], rct_q[3:2], rch_q};
    assign rxb = {(hbm_q && rct_q[1]) ? hpt_q : rct_q[0], rct_q[1],
                  rct_q[3:2], rch_q};

    // shadow of parameter registers and latched header flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tch_q <= 6'h00;
            tct_q <= 8'h00;
            rch_q <= 6'h00;
            rct_q <= 4'h0;
            hbm_q <= 1'b0;
            hpt_q <= 1'b0;
        end else begin
            if (wr_ok && paddr[5:2] == 4'h2) tch_q <= pwdata[5:0];
            if (wr_ok && paddr[5:2] == 4'h3) tct_q <= pwdata[7:0];
            if (wr_ok && paddr[5:2] == 4'h4) rch_q <= pwdata[5:0];
            if (wr_ok && paddr[5:2] == 4'h5) rct_q <= pwdata[3:0];
            if (hdr_valid) hbm_q <= hdr_burst_mode_flag;
            if (hdr_valid) hpt_q <= hdr_next_preamble_flag;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_frame_end;
        rx_en [*3] ##0 $fell(frame_active);
    endsequence

    a_apb_one_wait: assert property (s_access |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_decode: assert property (s_access |=> pslverr == $past(bad))
        else $error("pslverr wrong");
    a_tx_load: assert property (
        $rose(tx_en) |=> tx_loaded ##1 !tx_loaded)
        else $error("tx load missing");
    a_tx_only_rise: assert property (
        tx_loaded |-> $past(tx_en) && !$past(tx_en, 2))
        else $error("tx load spurious");
    a_tx_fields: assert property (
        $rose(tx_en) |=> tx_param == $past(txp))
        else $error("tx param wrong");
    a_rx_first: assert property (
        $rose(rx_en) |=> rx_loaded && rx_param == $past(rxp))
        else $error("rx first load wrong");
    a_rx_burst: assert property (
        s_frame_end |=> rx_loaded && rx_param == $past(rxb))
        else $error("rx burst load wrong");
    a_rx_idle: assert property (!rx_en |=> !rx_loaded)
        else $error("rx load while disabled");
endmodule : phy_frame_checker

bind phy_frame_control_registers phy_frame_checker chk_u (.*);

`default_nettype wire

// file: tb/tb.sv
`default_nettype none

module tb
    import phy_frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SU = 2;
    localparam int HO = 4;
    logic        clk, rst, fa, hv, hbm, hpt, rr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        tx_en, rx_en, tx_ld, rx_ld;
    logic [5:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  pm;
    tx_param_t   tx_param;
    rx_param_t   rx_param;
    int          error_cnt, n_tests, n_tx;

    // clock, 100 ns period
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // count tx load pulses
    always @(posedge clk) if (tx_ld === 1'b1) n_tx++;

    phy_frame_control_registers #(
        .tx_param_setup_cycles(SU), .tx_param_hold_cycles(HO),
        .rx_param_setup_cycles(SU), .rx_param_hold_cycles(HO)
    ) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_en(tx_en), .rx_en(rx_en), .frame_active(fa),
        .hdr_valid(hv), .hdr_burst_mode_flag(hbm),
        .hdr_next_preamble_flag(hpt), .range_run(rr),
        .tx_param(tx_param), .tx_loaded(tx_ld),
        .rx_param(rx_param), .rx_loaded(rx_ld), .power_mode(pm)
    );

    mac_model #(.SU(SU), .HO(HO)) mac_u (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_en(tx_en),
        .rx_en(rx_en)
    );

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // bus access, read data and error flag compared
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d, ex, input logic er);
        mac_u.xfer(w, a, d);
        if (mac_u.hung_q) begin
            error_cnt++;
            tally_and_finish();
        end
        if (!w) chk("prdata", mac_u.rd_q, ex);
        chk("pslverr", 32'(mac_u.err_q), 32'(er));
    endtask : acc

    task automatic hdr(input logic b, input logic p);
        hv <= 1'b1;
        hbm <= b;
        hpt <= p;
        @(posedge clk);
        hv <= 1'b0;
        @(posedge clk);
    endtask : hdr

    // frame end after setup, then hold, then next frame starts
    task automatic fend();
        repeat (SU) @(posedge clk);
        fa <= 1'b0;
        repeat (HO) @(posedge clk);
        fa <= 1'b1;
        @(posedge clk);
    endtask : fend

    task automatic s_reset();
        logic [5:0] a[6] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h2C};
        logic [7:0] e[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        chk("power_mode", 32'(pm), 32'h1);
        foreach (a[i]) acc(1'b0, a[i], 32'h0, 32'(e[i]), 1'b0);
        for (int i = 7; i < 11; i++) acc(1'b0, 6'(4 * i), 0, 0, 1'b0);
    endtask : s_reset

    task automatic s_regs();
        logic [5:0] a[6] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h2C};
        logic [7:0] w[6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'hA5};
        logic [7:0] e[6] = '{8'h3F, 8'hFD, 8'h3F, 8'h0F, 8'h02, 8'hA5};
        foreach (a[i]) acc(1'b1, a[i], 32'(w[i]), 0, 1'b0);
        foreach (a[i]) acc(1'b0, a[i], 0, 32'(e[i]), 1'b0);
        chk("power_mode", 32'(pm), 32'h2);
        acc(1'b1, 6'h00, 32'hFF, 0, 1'b1);
        acc(1'b0, 6'h00, 0, 0, 1'b1);
        acc(1'b0, 6'h0D, 0, 0, 1'b1);
        acc(1'b0, 6'h30, 0, 0, 1'b1);
        acc(1'b1, 6'h1C, 32'hFF, 0, 1'b0);
        acc(1'b0, 6'h1C, 0, 0, 1'b0);
    endtask : s_regs

    // ten run cycles give 4224 ticks, read low byte first
    task automatic s_range();
        rr <= 1'b1;
        repeat (10) @(posedge clk);
        rr <= 1'b0;
        @(posedge clk);
        acc(1'b0, 6'h1C, 0, 32'h80, 1'b0);
        acc(1'b0, 6'h20, 0, 32'h10, 1'b0);
        acc(1'b0, 6'h24, 0, 32'h00, 1'b0);
        acc(1'b0, 6'h28, 0, 32'h00, 1'b0);
    endtask : s_range

    task automatic s_tx();
        logic [7:0] ct;
        logic [5:0] ch;
        int         n;
        for (int i = 0; i < 4; i++) begin
            ct = {4'(3 * i + 1), 2'(i), 1'b0, 1'(i)};
            ch = 6'(9 * i + 1);
            acc(1'b1, 6'h08, 32'(ch), 0, 1'b0);
            acc(1'b1, 6'h0C, 32'(ct), 0, 1'b0);
            n = n_tx;
            mac_u.pulse_tx();
            chk("tx_param", 32'(tx_param),
                32'({ct[0], ct[3:2], ct[7:4], ch}));
            chk("tx_loads", 32'(n_tx - n), 32'h1);
        end
    endtask : s_tx

    task automatic s_rx();
        hdr(1'b1, 1'b1);
        acc(1'b1, 6'h10, 32'h2A, 0, 1'b0);
        acc(1'b1, 6'h14, 32'h0A, 0, 1'b0);
        mac_u.set_rx(1'b1);
        chk("rx_first", 32'(rx_param), 32'h1AA);
        fa <= 1'b1;
        acc(1'b1, 6'h14, 32'h06, 0, 1'b0);
        hdr(1'b1, 1'b1);
        fend();
        chk("rx_burst", 32'(rx_param), 32'h36A);
        acc(1'b1, 6'h14, 32'h05, 0, 1'b0);
        hdr(1'b1, 1'b0);
        fend();
        chk("rx_no_hdr", 32'(rx_param), 32'h26A);
        acc(1'b1, 6'h14, 32'h07, 0, 1'b0);
        mac_u.set_rx(1'b0);
        mac_u.set_rx(1'b1);
        chk("rx_reload", 32'(rx_param), 32'h36A);
    endtask : s_rx

    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        fa = 1'b0;
        hv = 1'b0;
        hbm = 1'b0;
        hpt = 1'b0;
        rr = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        n_tx = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_reset();
        s_regs();
        s_range();
        s_tx();
        s_rx();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
